// ### src/list_mgr_regs.svh
// Register offsets, field positions, reset values and timing of the list manager front end
`ifndef LIST_MGR_REGS_SVH
`define LIST_MGR_REGS_SVH

`define LM_OFS_IDENT      8'h00
`define LM_OFS_LOCATION   8'h04
`define LM_OFS_ATTR       8'h08
`define LM_OFS_STATUS     8'h0c
`define LM_OFS_PORT_ADDR  8'h10
`define LM_OFS_PORT_DATA  8'h14
`define LM_OFS_BG_RGB     8'h18
`define LM_OFS_BG_YUV     8'h1c
`define LM_OFS_DESC_UP    8'h20
`define LM_OFS_DESC_LO    8'h24
`define LM_OFS_DESC_CUR   8'h28

`define SEQUENCER_ATTRIBUTE_REG_SLOT_LSB  24
`define SEQUENCER_ATTRIBUTE_REG_SLOT_MSB  26
`define SEQUENCER_ATTRIBUTE_REG_STOP_BIT  20
`define SEQUENCER_ATTRIBUTE_REG_RDY_BIT   19
`define SEQUENCER_ATTRIBUTE_REG_KIND_LSB  16
`define SEQUENCER_ATTRIBUTE_REG_KIND_MSB  18
`define SEQUENCER_ATTRIBUTE_REG_SIZE_LSB  0
`define SEQUENCER_ATTRIBUTE_REG_SIZE_MSB  15

`define LM_STAT_RUN_LSB   16
`define LM_STAT_RUN_MSB   23
`define LM_STAT_SYNC_LSB  0
`define LM_STAT_SYNC_MSB  7

`define LM_IDENT_DONE_BIT 7
`define LM_IDENT_ACC_BIT  6

`define LM_RST_WORD       32'h0000_0000
`define LM_ACK_LATENCY    1

`endif

// ### src/list_mgr_pkg.sv
// Types shared by the list manager register front end
package list_mgr_pkg;

  typedef enum logic [1:0] {
    LIST_NORMAL   = 2'h0,
    LIST_SELF_MOD = 2'h1,
    LIST_DOORBELL = 2'h2,
    LIST_RESERVED = 2'h3
  } list_kind_e;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'h0,
    BUS_ACK  = 1'h1
  } bus_state_e;

  typedef struct packed {
    logic [31:0] location;
    logic [15:0] size;
    logic [2:0]  kind_code;
    list_kind_e  kind;
    logic [2:0]  slot;
  } list_submit_s;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
    logic [7:0] blend;
  } rgb_colour_s;

  typedef struct packed {
    logic [7:0] luma;
    logic [7:0] blank_red_difference;
    logic [7:0] blank_blue_difference;
  } yuv_colour_s;

endpackage : list_mgr_pkg

// ### src/list_mgr.sv
// Wishbone register front end of the video DMA descriptor-list manager
// Function
// - 32-bit list location register, reset zero
// - Size write submits list and starts fetch
// - Slot number bits 26-24 name list
// - Submit to active slot blocks submissions
// - Stop bit sends slot a stop request
// - Ready low while loading or blocked
// - Location writes refused while not ready
// - List type: normal, self-modifying, doorbell
// - Eight running flags, one per slot
// - Busy-slot load locks location and attributes
// - Write-one sync bits fire per-slot sync
// - Background RGB and blend bytes driven out
// - Background Y, Cr, Cb bytes driven out
// - Load-done flag in identification bit 7
`include "list_mgr_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module list_mgr
  import list_mgr_pkg::*;
#(
  // Identification fields: values are arbitrary
  parameter logic [1:0]  IDENT_SCHEME = 2'h1,
  parameter logic [13:0] IDENT_FUNC   = 14'h0a5a,
  parameter logic [4:0]  IDENT_RTL    = 5'h01,
  parameter logic [2:0]  IDENT_MAJOR  = 3'h1,
  parameter logic [5:0]  IDENT_MINOR  = 6'h00
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // List engine side
  input  wire logic        image_loaded_i,
  input  wire logic [7:0]  slot_done_i,
  output logic             submit_valid_o,
  output list_submit_s     submit_o,
  output logic             stop_valid_o,
  output logic      [2:0]  stop_slot_o,
  output logic      [7:0]  slot_sync_trigger_o,
  output logic      [7:0]  slot_running_flag_o,
  output logic             ready_o,
  output rgb_colour_s      bg_rgb_o,
  output yuv_colour_s      bg_yuv_o
);

  bus_state_e   bus_state;
  logic [31:0]  sequencer_location_reg;
  logic [2:0]   attr_slot;
  logic [2:0]   attr_kind;
  logic [15:0]  attr_size;
  logic [7:0]   slot_running_flag;
  logic         blocked;
  logic [2:0]   blocked_slot;
  logic         load_done;
  logic         wr_take;
  logic         rd_take;
  logic         ready;
  logic         attr_wr;
  logic         size_wr;
  logic         stop_wr;
  logic [2:0]   next_slot;
  logic [2:0]   next_kind;
  logic [15:0]  next_size;
  logic [31:0]  sequencer_attribute_reg;
  logic [31:0]  next_dat;
  logic [31:0]  size_merge;
  logic [31:0]  yuv_merge;
  logic         hit_ident;
  logic         hit_location;
  logic         hit_attr;
  logic         hit_status;
  logic         hit_bg_rgb;
  logic         hit_bg_yuv;
  logic         loc_wr;
  logic         sync_wr;
  logic         rgb_wr;
  logic         yuv_wr;
  logic         attr_take;
  logic         launch_req;
  logic         submit_go;
  logic         block_go;
  logic         release_ok;

  // Byte-lane merge of a write into an existing word
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  function automatic list_kind_e kind_decode(input logic [2:0] code);
    list_kind_e k;
    case (code)
      3'h0:    k = LIST_NORMAL;
      3'h1:    k = LIST_SELF_MOD;
      3'h2:    k = LIST_DOORBELL;
      default: k = LIST_RESERVED;
    endcase
    return k;
  endfunction : kind_decode

  function automatic logic [7:0] slot_onehot(input logic [2:0] slot);
    return 8'h01 << slot;
  endfunction : slot_onehot

  // Register select; an unmapped or reserved offset raises no hit at all
  function automatic logic [5:0] reg_decode(input logic [7:0] adr);
    logic [5:0] hit;
    hit = 6'h00;
    if (adr == `LM_OFS_IDENT) begin
      hit[0] = 1'b1;
    end else if (adr == `LM_OFS_LOCATION) begin
      hit[1] = 1'b1;
    end else if (adr == `LM_OFS_ATTR) begin
      hit[2] = 1'b1;
    end else if (adr == `LM_OFS_STATUS) begin
      hit[3] = 1'b1;
    end else if (adr == `LM_OFS_BG_RGB) begin
      hit[4] = 1'b1;
    end else if (adr == `LM_OFS_BG_YUV) begin
      hit[5] = 1'b1;
    end
    return hit;
  endfunction : reg_decode

  // Requests are taken once; the ack cycle itself is not a new request
  assign wr_take = cyc_i && stb_i && !ack_o && we_i;
  assign rd_take = cyc_i && stb_i && !ack_o && !we_i;

  assign ready = load_done && !blocked;

  // reserved offsets raise no hit, so no strobe and no side effect
  assign {hit_bg_yuv, hit_bg_rgb, hit_status, hit_attr, hit_location, hit_ident} = reg_decode(adr_i);
  // The identification word has no write strobe: it is read-only
  assign loc_wr  = wr_take && hit_location;
  assign sync_wr = wr_take && hit_status && sel_i[0];
  assign rgb_wr  = wr_take && hit_bg_rgb;
  assign yuv_wr  = wr_take && hit_bg_yuv;
  assign attr_wr = wr_take && hit_attr;
  assign size_wr = attr_wr && (sel_i[0] || sel_i[1]);
  assign stop_wr = attr_wr && sel_i[2] && dat_i[`SEQUENCER_ATTRIBUTE_REG_STOP_BIT];
  // while locked a write neither updates, launches nor re-blocks
  assign attr_take  = attr_wr && ready && !stop_wr;
  assign launch_req = attr_take && size_wr;
  // Busy is judged on next_slot: the slot byte written now, or the stored one when sel_i[3] is low
  assign submit_go  = launch_req && !slot_running_flag[next_slot];
  assign block_go   = launch_req && slot_running_flag[next_slot];

  always_comb begin
    size_merge = lane_merge({16'h0000, attr_size}, dat_i, sel_i);
    yuv_merge  = lane_merge({8'h00, bg_yuv_o}, dat_i, sel_i);
    next_slot  = sel_i[3] ? dat_i[`SEQUENCER_ATTRIBUTE_REG_SLOT_MSB:`SEQUENCER_ATTRIBUTE_REG_SLOT_LSB] : attr_slot;
    next_kind  = sel_i[2] ? dat_i[`SEQUENCER_ATTRIBUTE_REG_KIND_MSB:`SEQUENCER_ATTRIBUTE_REG_KIND_LSB] : attr_kind;
    next_size  = size_merge[15:0];
  end

  always_comb begin
    sequencer_attribute_reg = 32'h0000_0000;
    sequencer_attribute_reg[`SEQUENCER_ATTRIBUTE_REG_SLOT_MSB:`SEQUENCER_ATTRIBUTE_REG_SLOT_LSB] = attr_slot;
    sequencer_attribute_reg[`SEQUENCER_ATTRIBUTE_REG_RDY_BIT] = ready;
    sequencer_attribute_reg[`SEQUENCER_ATTRIBUTE_REG_KIND_MSB:`SEQUENCER_ATTRIBUTE_REG_KIND_LSB] = attr_kind;
    sequencer_attribute_reg[`SEQUENCER_ATTRIBUTE_REG_SIZE_MSB:`SEQUENCER_ATTRIBUTE_REG_SIZE_LSB] = attr_size;
  end

  // Read mux; the stop and sync bits are write-only and read zero
  always_comb begin
    next_dat = `LM_RST_WORD;
    if (hit_ident) begin
      next_dat = {IDENT_SCHEME, IDENT_FUNC, IDENT_RTL, IDENT_MAJOR, 1'b0, 1'b0, IDENT_MINOR};
      next_dat[`LM_IDENT_DONE_BIT] = load_done;
    end else if (hit_location) begin
      next_dat = sequencer_location_reg;
    end else if (hit_attr) begin
      next_dat = sequencer_attribute_reg;
    end else if (hit_status) begin
      next_dat[`LM_STAT_RUN_MSB:`LM_STAT_RUN_LSB] = slot_running_flag;
    end else if (hit_bg_rgb) begin
      next_dat = bg_rgb_o;
    end else if (hit_bg_yuv) begin
      next_dat = {8'h00, bg_yuv_o};
    end else begin
      next_dat = `LM_RST_WORD;
    end
  end

  // Bus handshake: ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_state <= BUS_IDLE;
      ack_o     <= 1'b0;
      dat_o     <= `LM_RST_WORD;
    end else begin
      case (bus_state)
        BUS_IDLE: begin
          if (wr_take || rd_take) begin
            bus_state <= BUS_ACK;
            ack_o     <= 1'b1;
            dat_o     <= rd_take ? next_dat : `LM_RST_WORD;
          end
        end
        BUS_ACK: begin
          bus_state <= BUS_IDLE;
          ack_o     <= 1'b0;
          dat_o     <= `LM_RST_WORD;
        end
        default: begin
          bus_state <= BUS_IDLE;
          ack_o     <= 1'b0;
          dat_o     <= `LM_RST_WORD;
        end
      endcase
    end
  end

  // Firmware image load status, sampled as a plain synchronous input
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_done <= 1'b0;
    end else begin
      load_done <= image_loaded_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sequencer_location_reg <= `LM_RST_WORD;
    end else if (loc_wr) begin
      if (ready) begin
        sequencer_location_reg <= lane_merge(sequencer_location_reg, dat_i, sel_i);
      end
    end
  end

  // attributes locked while blocked or loading
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      attr_slot <= 3'h0;
      attr_kind <= 3'h0;
      attr_size <= 16'h0000;
    end else if (attr_take) begin
      attr_slot <= next_slot;
      attr_kind <= next_kind;
      attr_size <= next_size;
    end
  end

  // Submission to the list engine; a busy slot blocks instead of launching
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      submit_valid_o <= 1'b0;
      submit_o       <= '0;
    end else begin
      submit_valid_o <= 1'b0;
      if (submit_go) begin
        submit_valid_o     <= 1'b1;
        submit_o.location  <= sequencer_location_reg;
        submit_o.size      <= next_size;
        submit_o.kind_code <= next_kind;
        submit_o.kind      <= kind_decode(next_kind);
        submit_o.slot      <= next_slot;
      end
    end
  end

  // A blocked list is dropped, not queued: software must write it again
  assign release_ok = !slot_running_flag[blocked_slot];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blocked      <= 1'b0;
      blocked_slot <= 3'h0;
    end else if (block_go) begin
      blocked      <= 1'b1;
      blocked_slot <= next_slot;
    end else if (blocked && release_ok) begin
      // ready returns once the slot frees
      blocked <= 1'b0;
    end
  end

  // running flags; a new submission wins over a completion
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slot_running_flag <= 8'h00;
    end else if (submit_valid_o) begin
      slot_running_flag <= (slot_running_flag & ~slot_done_i) | slot_onehot(submit_o.slot);
    end else begin
      slot_running_flag <= slot_running_flag & ~slot_done_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stop_valid_o <= 1'b0;
      stop_slot_o  <= 3'h0;
    end else begin
      stop_valid_o <= stop_wr;
      if (stop_wr) begin
        stop_slot_o <= next_slot;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slot_sync_trigger_o <= 8'h00;
    end else if (sync_wr) begin
      slot_sync_trigger_o <= dat_i[`LM_STAT_SYNC_MSB:`LM_STAT_SYNC_LSB];
    end else begin
      slot_sync_trigger_o <= 8'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bg_rgb_o <= `LM_RST_WORD;
    end else if (rgb_wr) begin
      bg_rgb_o <= lane_merge(bg_rgb_o, dat_i, sel_i);
    end
  end

  // background YUV colour, top byte reserved
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bg_yuv_o <= '0;
    end else if (yuv_wr) begin
      bg_yuv_o <= yuv_merge[23:0];
    end
  end

  // Registered copies for the engine side
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slot_running_flag_o <= 8'h00;
      ready_o             <= 1'b0;
    end else begin
      slot_running_flag_o <= slot_running_flag;
      ready_o             <= ready;
    end
  end

endmodule : list_mgr

`default_nettype wire

// ### tb/list_mgr_assertions.sv
// Port-level checks of the list manager front end
`timescale 1ns/1ps
`default_nettype none
module list_mgr_assertions
  import list_mgr_pkg::*;
(
  input wire logic         clk_i,
  input wire logic         rst_i,
  input wire logic         cyc_i,
  input wire logic         stb_i,
  input wire logic         we_i,
  input wire logic [7:0]   adr_i,
  input wire logic [3:0]   sel_i,
  input wire logic [31:0]  dat_i,
  input wire logic [31:0]  dat_o,
  input wire logic         ack_o,
  input wire logic         image_loaded_i,
  input wire logic         submit_valid_o,
  input wire list_submit_s submit_o,
  input wire logic         stop_valid_o,
  input wire logic [2:0]   stop_slot_o,
  input wire logic [7:0]   slot_sync_trigger_o,
  input wire logic [7:0]   slot_running_flag_o,
  input wire logic         ready_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic req = cyc_i && stb_i && !ack_o;
  chk_bus_answer:
  assert property (req |=> ack_o ##1 !ack_o) else $error("ack not one cycle after request");
  chk_rsvd_zero:
  assert property (req && !we_i && adr_i inside {8'h10, 8'h14, 8'h20, 8'h24, 8'h28, 8'h2c} |=> dat_o == 32'h0)
    else $error("reserved read not zero");
  chk_submit_cause:
  assert property (submit_valid_o |-> ack_o
    && $past(we_i && adr_i == 8'h08 && |sel_i[1:0] && !(sel_i[2] && dat_i[20])))
    else $error("submit without size write");
  chk_submit_fields:
  assert property (submit_valid_o && $past(sel_i) == 4'hf |-> submit_o.slot == $past(dat_i[26:24])
    && submit_o.kind_code == $past(dat_i[18:16]) && submit_o.size == $past(dat_i[15:0])) else $error("submit fields");
  chk_kind_decode:
  assert property (submit_valid_o |-> submit_o.kind == (submit_o.kind_code < 3'h3 ?
    list_kind_e'(submit_o.kind_code[1:0]) : LIST_RESERVED)) else $error("list type decode");
  chk_run_set:
  assert property (submit_valid_o |-> ##[1:3] slot_running_flag_o[submit_o.slot]) else $error("running flag not set");
  chk_busy_hold:
  assert property (!ready_o && $past(!ready_o) |-> !submit_valid_o) else $error("submit while not ready");
  chk_stop_req:
  assert property (stop_valid_o |-> ack_o && !submit_valid_o && stop_slot_o == $past(dat_i[26:24]))
    else $error("stop request");
  chk_sync_map:
  assert property (ack_o && $past(we_i && adr_i == 8'h0c && sel_i[0]) |-> slot_sync_trigger_o == $past(dat_i[7:0]))
    else $error("sync pulses");
  cover property (submit_valid_o);
  cover property (stop_valid_o);
  cover property (image_loaded_i && !ready_o);
endmodule : list_mgr_assertions
bind list_mgr list_mgr_assertions u_list_mgr_assertions (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
  .dat_i, .dat_o, .ack_o, .image_loaded_i, .submit_valid_o, .submit_o, .stop_valid_o, .stop_slot_o,
  .slot_sync_trigger_o, .slot_running_flag_o, .ready_o);
`default_nettype wire

// ### tb/list_engine_model.sv
// Behavioural list engine: image load delay and per-slot run time
`timescale 1ns/1ps
`default_nettype none
module list_engine_model
  import list_mgr_pkg::*;
#(
  parameter int LOAD_CYC = 60,
  parameter int RUN_CYC  = 12
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         hold_i,
  input  wire logic         submit_valid_i,
  input  wire list_submit_s submit_i,
  input  wire logic         stop_valid_i,
  input  wire logic [2:0]   stop_slot_i,
  output logic              image_loaded_o,
  output logic [7:0]        slot_done_o
);
  logic [7:0] boot;
  logic [7:0] cnt [8];
  always_ff @(posedge clk_i) begin
    if (rst_i) boot <= 8'h00;
    else if (boot != LOAD_CYC[7:0]) boot <= boot + 8'h01;
  end
  assign image_loaded_o = (boot == LOAD_CYC[7:0]);
  always_ff @(posedge clk_i) begin
    for (int s = 0; s < 8; s++) begin
      slot_done_o[s] <= 1'b0;
      if (rst_i) cnt[s] <= 8'h00;
      else if (submit_valid_i && submit_i.slot == 3'(s)) cnt[s] <= RUN_CYC[7:0];
      // A stop cuts the remaining run of the slot down to two cycles
      else if (stop_valid_i && stop_slot_i == 3'(s) && cnt[s] > 8'h02) cnt[s] <= 8'h02;
      else if (cnt[s] == 8'h01 && !hold_i) begin
        cnt[s] <= 8'h00;
        slot_done_o[s] <= 1'b1;
      end else if (cnt[s] > 8'h01) cnt[s] <= cnt[s] - 8'h01;
    end
  end
endmodule : list_engine_model
`default_nettype wire

// ### tb/list_mgr_tb.sv
// Self-checking bench of the list manager front end
`timescale 1ns/1ps
`default_nettype none
module list_mgr_tb
  import list_mgr_pkg::*;
;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, hold = 1'b0;
  logic [7:0] adr_i = 8'h00, slot_done_i, slot_sync_trigger_o, slot_running_flag_o, sy;
  logic [3:0] sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0, dat_o, q, d;
  logic ack_o, submit_valid_o, stop_valid_o, ready_o, image_loaded_i, sv, pv;
  logic [2:0] stop_slot_o, ps;
  list_submit_s submit_o, sb;
  rgb_colour_s bg_rgb_o;
  yuv_colour_s bg_yuv_o;
  int mismatches = 0, checks_done = 0, seed = 18872;
  always #12.5 clk_i = ~clk_i;
  list_mgr u_list_mgr (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
    .image_loaded_i, .slot_done_i, .submit_valid_o, .submit_o, .stop_valid_o, .stop_slot_o,
    .slot_sync_trigger_o, .slot_running_flag_o, .ready_o, .bg_rgb_o, .bg_yuv_o);
  list_engine_model u_list_engine_model (.clk_i, .rst_i, .hold_i(hold), .submit_valid_i(submit_valid_o),
    .submit_i(submit_o), .stop_valid_i(stop_valid_o), .stop_slot_i(stop_slot_o),
    .image_loaded_o(image_loaded_i), .slot_done_o(slot_done_i));
  task automatic wrap_up;
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  task automatic cmp(input logic [63:0] g, input logic [63:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  // Request held until ack is seen, all results taken at that edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= v;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      mismatches++;
      wrap_up();
    end
    {q, sv, sb, pv, ps, sy} = {dat_o, submit_valid_o, submit_o, stop_valid_o, stop_slot_o, slot_sync_trigger_o};
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    for (int i = 0; i < 40; i++) begin
      bus(1'b0, a, 32'h0);
      if ((q & m) === e) return;
    end
    mismatches++;
    wrap_up();
  endtask : poll
  task automatic submit(input logic [2:0] s, input logic [2:0] t, input logic [15:0] n);
    bus(1'b1, 8'h08, {5'h00, s, 5'h00, t, n});
  endtask : submit
  function automatic list_kind_e kind_of(input logic [2:0] c);
    return (c < 3'h3) ? list_kind_e'(c[1:0]) : LIST_RESERVED;
  endfunction : kind_of
  // Reserved offsets only; the colour registers sit between them
  function automatic logic [7:0] rsvd_adr(input int i);
    return (i < 2) ? 8'h10 + 8'(i * 4) : 8'h18 + 8'(i * 4);
  endfunction : rsvd_adr
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int a = 4; a <= 44; a += 4) begin
      bus(1'b0, 8'(a), 32'h0);
      cmp(q, 0);
    end
    bus(1'b1, 8'h04, 32'h5a5a_0001);
    bus(1'b0, 8'h04, 32'h0);
    cmp(q, 0);
    bus(1'b0, 8'h00, 32'h0);
    cmp(q[7], 0);
    poll(8'h08, 32'h0008_0000, 32'h0008_0000);
    bus(1'b0, 8'h00, 32'h0);
    cmp(q[7:6], 2'b10);
    $display("test load done");
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      bus(1'b1, 8'h04, d);
      bus(1'b0, 8'h04, 32'h0);
      cmp(q, d);
      bus(1'b1, 8'h18, d);
      cmp(bg_rgb_o, d);
      bus(1'b1, 8'h1c, d);
      bus(1'b0, 8'h1c, 32'h0);
      cmp({q, bg_yuv_o}, {8'h00, d[23:0], d[23:0]});
      bus(1'b1, rsvd_adr(i), d);
      bus(1'b0, rsvd_adr(i), 32'h0);
      cmp(q, 0);
    end
    $display("test registers done");
    for (int t = 0; t < 8; t++) begin
      d = $random(seed);
      bus(1'b1, 8'h04, d);
      submit(3'(t), 3'(t), d[15:0] | 16'h1);
      cmp({sv, sb}, {1'b1, d, d[15:0] | 16'h1, 3'(t), kind_of(3'(t)), 3'(t)});
      bus(1'b0, 8'h0c, 32'h0);
      cmp(q[16 + t], 1);
    end
    poll(8'h0c, 32'h00ff_0000, 32'h0);
    $display("test submit done");
    hold <= 1'b1;
    submit(3'h3, 3'h0, 16'h0010);
    submit(3'h3, 3'h1, 16'h0020);
    cmp(sv, 0);
    bus(1'b0, 8'h08, 32'h0);
    cmp(q[19], 0);
    bus(1'b1, 8'h04, 32'hdead_0000);
    bus(1'b0, 8'h04, 32'h0);
    cmp(q, d);
    submit(3'h5, 3'h0, 16'h0001);
    cmp(sv, 0);
    hold <= 1'b0;
    poll(8'h08, 32'h0008_0000, 32'h0008_0000);
    bus(1'b1, 8'h04, 32'hdead_0000);
    bus(1'b0, 8'h04, 32'h0);
    cmp(q, 32'hdead_0000);
    submit(3'h2, 3'h0, 16'h0004);
    bus(1'b1, 8'h08, 32'h0210_0000);
    cmp({sv, pv, ps}, {1'b0, 1'b1, 3'h2});
    poll(8'h0c, 32'h0004_0000, 32'h0);
    $display("test lock and stop done");
    for (int s = 0; s < 9; s++) begin
      d = (s < 8) ? 32'h1 << s : $random(seed);
      bus(1'b1, 8'h0c, d);
      cmp(sy, d[7:0]);
    end
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, 8'h04, 32'h0);
    cmp({q, bg_rgb_o}, 0);
    $display("test sync and reset done");
    wrap_up();
  end
endmodule : list_mgr_tb
`default_nettype wire
